// ---- sgsw_defines.vh ----
`ifndef SGSW_DEFINES_VH
`define SGSW_DEFINES_VH

// register byte offsets
`define SGSW_OFF_CTRL    12'h000
`define SGSW_OFF_HOLD    12'h004
`define SGSW_OFF_TRANS   12'h008
`define SGSW_OFF_PAIR0   12'h00C
`define SGSW_OFF_STATUS  12'h024
`define SGSW_PAIR_STEP   12'h004

// control register fields
`define SGSW_PAT_LSB     0
`define SGSW_PAT_MSB     3
`define SGSW_CA_LSB      4
`define SGSW_CA_MSB      7
`define SGSW_CB_LSB      8
`define SGSW_CB_MSB      11
`define SGSW_LD_BIT      12
`define SGSW_IC_LSB      16
`define SGSW_IC_MSB      17
`define SGSW_CTRL_W      18
`define SGSW_PAT_AUTO1   4'h1

// integral compensation codes
`define SGSW_IC_OFF      2'h0
`define SGSW_IC_BOTH     2'h1
`define SGSW_IC_PRI      2'h2
`define SGSW_IC_SEC      2'h3

// reset values, primary in [15:0], secondary in [31:16]
`define SGSW_CTRL_RST    18'h00000
`define SGSW_HOLD_RST    32'h00000000
`define SGSW_TRANS_RST   32'h00000000
`define SGSW_RST_SPD     32'h01900190
`define SGSW_RST_INT     32'h07D007D0
`define SGSW_RST_POS     32'h01900190
`define SGSW_RST_TQ      32'h00640064
`define SGSW_RST_RIG     32'h003C003C
`define SGSW_RST_FB      32'h00000000

// accepted ranges of the secondary loop gains
`define SGSW_SPD_MIN     16'h000A
`define SGSW_SPD_MAX     16'h4E20
`define SGSW_INT_MIN     16'h000F
`define SGSW_INT_MAX     16'hC800
`define SGSW_POS_MIN     16'h000A
`define SGSW_POS_MAX     16'h4E20

// timing: one millisecond tick from the 20 ns control clock
`define SGSW_CLK_NS      20
`define SGSW_TICK_NS     1000000
`define SGSW_TICK_CYC    (`SGSW_TICK_NS / `SGSW_CLK_NS)

`endif

// ---- sgsw_tick.v ----
`timescale 1ns/1ns
`include "sgsw_defines.vh"
// free running millisecond tick, one cycle wide
module sgsw_tick #(
   parameter integer CYC = `SGSW_TICK_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   output reg         tick_q
);
   reg [31:0] cnt_q;

   // count down rather than compare to a variable limit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= 32'h00000000;
         tick_q <= 1'b0;
      end else if (cnt_q == 32'h00000000) begin
         cnt_q  <= CYC - 1;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q - 32'h00000001;
         tick_q <= 1'b0;
      end
   end
endmodule // sgsw_tick

// ---- sgsw_ramp.v ----
`timescale 1ns/1ns
// moves one gain from its value to the chosen set's value over dur ms
module sgsw_ramp #(
   parameter integer W = 16
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         tick,
   input  wire         start,
   input  wire         force_pri,
   input  wire         sel,
   input  wire [15:0]  dur,
   input  wire [W-1:0] val_a,
   input  wire [W-1:0] val_b,
   output reg          busy_q,
   output reg  [W-1:0] val_q
);
   reg  [W-1:0] tgt_q;
   reg  [W-1:0] inc_q;
   reg  [15:0]  rem_q;
   reg  [15:0]  racc_q;
   reg          up_q;
   reg  [15:0]  elap_q;
   wire [W-1:0] tgt_d  = sel ? val_b : val_a;
   wire         up_d   = (tgt_d >= val_q);
   wire [W-1:0] mag_d  = up_d ? tgt_d - val_q : val_q - tgt_d;
   // a zero divisor is never latched: zero time takes the direct step
   wire [31:0]  quo_w  = {{(32-W){1'b0}}, mag_d} / {16'h0000, dur};
   wire [31:0]  mod_w  = {{(32-W){1'b0}}, mag_d} % {16'h0000, dur};
   wire [16:0]  racc_n = {1'b0, racc_q} + {1'b0, rem_q};
   wire [16:0]  racc_c = racc_n - {1'b0, dur};
   wire         carry  = (racc_n >= {1'b0, dur});
   wire [W-1:0] delta  = inc_q + {{(W-1){1'b0}}, carry};

   // per tick move the whole quotient, spreading the remainder evenly,
   // so the slope does not depend on how many clocks make a tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         val_q  <= {W{1'b0}};
         tgt_q  <= {W{1'b0}};
         inc_q  <= {W{1'b0}};
         rem_q  <= 16'h0000;
         racc_q <= 16'h0000;
         up_q   <= 1'b0;
         elap_q <= 16'h0000;
      end else if (force_pri) begin
         busy_q <= 1'b0;
         val_q  <= val_a;
      end else if (start) begin
         tgt_q  <= tgt_d;
         up_q   <= up_d;
         elap_q <= 16'h0000;
         racc_q <= 16'h0000;
         if (dur == 16'h0000) begin
            val_q  <= tgt_d;   // zero time means a direct step
            busy_q <= 1'b0;
         end else begin
            inc_q  <= quo_w[W-1:0];
            rem_q  <= mod_w[15:0];
            busy_q <= 1'b1;
         end
      end else if (busy_q) begin
         if (tick) begin
            elap_q <= elap_q + 16'h0001;
            racc_q <= carry ? racc_c[15:0] : racc_n[15:0];
            if (elap_q + 16'h0001 == dur) begin
               val_q  <= tgt_q;
               busy_q <= 1'b0;
            end else begin
               val_q  <= up_q ? val_q + delta : val_q - delta;
            end
         end
      end else begin
         val_q <= tgt_d;   // idle: follow the settled set
      end
   end
endmodule // sgsw_ramp

// ---- sgsw_top.v ----
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
`include "sgsw_defines.vh"
module sgsw_top #(
   parameter integer TICK_CYC = `SGSW_TICK_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        servo_on,
   input  wire        alarm,
   input  wire        positioning_complete_one,
   input  wire [14:0] cond_in,
   output wire [15:0] speed_gain_q,
   output wire [15:0] speed_integral_q,
   output wire [15:0] position_gain_q,
   output wire [15:0] torque_filter_q,
   output wire [15:0] rigidity_q,
   output wire [15:0] fb_filter_q,
   output reg         integ_comp_en_q,
   output reg         active_set_q,
   output reg         switching_q
);
   localparam integer NCH = 6;

   // one-hot switching states
   localparam [5:0] S_PRI = 6'h01;
   localparam [5:0] S_WA  = 6'h02;
   localparam [5:0] S_RA  = 6'h04;
   localparam [5:0] S_SEC = 6'h08;
   localparam [5:0] S_WB  = 6'h10;
   localparam [5:0] S_RB  = 6'h20;

   reg  [`SGSW_CTRL_W-1:0] ctrl_q;
   reg  [31:0]             hold_q;
   reg  [31:0]             trans_q;
   reg  [31:0]             pair_q [0:NCH-1];
   reg  [5:0]              state_q;
   reg  [15:0]             cnt_q;
   reg  [15:0]             dur_q;
   reg                     tgt_q;
   reg                     start_q;
   reg                     force_q;
   reg  [31:0]             rd_d;
   reg                     hit_d;
   integer                 i;

   wire                    tick;
   wire [NCH-1:0]          pair_hit;
   wire [NCH-1:0]          ramp_busy;
   wire [16*NCH-1:0]       chan_val;
   wire [15:0]             cond_vec;
   wire                    auto_on;
   wire                    ld_mode;
   wire                    cond_a;
   wire                    cond_b;
   wire                    off;
   wire                    setup;
   wire                    wr_en;
   wire [1:0]              ic_mode;
   wire [15:0]             hold_one;
   wire [15:0]             hold_two;
   wire [15:0]             trans_one;
   wire [15:0]             trans_two;

   // apb phases: answer in the access cycle, no wait states
   assign setup   = psel & ~penable;
   assign wr_en   = psel & penable & pwrite & pready;

   assign auto_on = (ctrl_q[`SGSW_PAT_MSB:`SGSW_PAT_LSB] == `SGSW_PAT_AUTO1);
   assign ld_mode = ctrl_q[`SGSW_LD_BIT];
   assign ic_mode = ctrl_q[`SGSW_IC_MSB:`SGSW_IC_LSB];
   assign off     = ~servo_on | alarm;

   assign hold_one  = hold_q[15:0];
   assign hold_two  = hold_q[31:16];
   assign trans_one = trans_q[15:0];
   assign trans_two = trans_q[31:16];

   // index 0 is the positioning-complete input, the rest are plain status
   assign cond_vec = {cond_in, positioning_complete_one};
   assign cond_a   = cond_vec[ctrl_q[`SGSW_CA_MSB:`SGSW_CA_LSB]];
   assign cond_b   = cond_vec[ctrl_q[`SGSW_CB_MSB:`SGSW_CB_LSB]];

   assign speed_gain_q     = chan_val[15:0];
   assign speed_integral_q = chan_val[31:16];
   assign position_gain_q  = chan_val[47:32];
   assign torque_filter_q  = chan_val[63:48];
   assign rigidity_q       = chan_val[79:64];
   assign fb_filter_q      = chan_val[95:80];

   // limit a written value to its accepted range
   function [15:0] clamp;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   sgsw_tick #(
      .CYC     (TICK_CYC)
   ) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick_q  (tick)
   );

   // control and timing registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `SGSW_CTRL_RST;
         hold_q  <= `SGSW_HOLD_RST;
         trans_q <= `SGSW_TRANS_RST;
      end else if (wr_en) begin
         if (paddr == `SGSW_OFF_CTRL) begin
            ctrl_q <= pwdata[`SGSW_CTRL_W-1:0];
         end
         if (paddr == `SGSW_OFF_HOLD) begin
            hold_q <= pwdata;
         end
         if (paddr == `SGSW_OFF_TRANS) begin
            trans_q <= pwdata;
         end
      end
   end

   // gain pairs and one ramp per gain; channels 0-3 standard, 4-5 less-deviation
   genvar k;
   generate
      for (k = 0; k < NCH; k = k + 1) begin : g_chan
         localparam integer KOFF = `SGSW_OFF_PAIR0 + `SGSW_PAIR_STEP * k;
         localparam [15:0]  LO   = (k == 0) ? `SGSW_SPD_MIN :
                                   (k == 1) ? `SGSW_INT_MIN : `SGSW_POS_MIN;
         localparam [15:0]  HI   = (k == 0) ? `SGSW_SPD_MAX :
                                   (k == 1) ? `SGSW_INT_MAX : `SGSW_POS_MAX;
         localparam [31:0]  RST  = (k == 0) ? `SGSW_RST_SPD :
                                   (k == 1) ? `SGSW_RST_INT :
                                   (k == 2) ? `SGSW_RST_POS :
                                   (k == 3) ? `SGSW_RST_TQ  :
                                   (k == 4) ? `SGSW_RST_RIG : `SGSW_RST_FB;
         localparam         STD  = (k < 4);
         wire               en;

         assign pair_hit[k] = (paddr == KOFF[11:0]);
         // a channel follows the switch only in its own control method
         assign en = ld_mode ? ~STD : STD;

         // only the three secondary loop gains carry a range
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pair_q[k] <= RST;
            end else if (wr_en && pair_hit[k]) begin
               pair_q[k][15:0] <= pwdata[15:0];
               if (k < 3) begin
                  pair_q[k][31:16] <= clamp(pwdata[31:16], LO, HI);
               end else begin
                  pair_q[k][31:16] <= pwdata[31:16];
               end
            end
         end

         sgsw_ramp #(
            .W       (16)
         ) u_ramp (
            .pclk    (pclk),
            .presetn (presetn),
            .tick    (tick),
            .start   (start_q),
            .force_pri (force_q),
            .sel     (tgt_q & en),
            .dur     (dur_q),
            .val_a   (pair_q[k][15:0]),
            .val_b   (pair_q[k][31:16]),
            .busy_q  (ramp_busy[k]),
            .val_q   (chan_val[16*k+15:16*k])
         );
      end
   endgenerate

   // switching sequence; servo off or alarm beats everything else
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q      <= S_PRI;
         cnt_q        <= 16'h0000;
         dur_q        <= 16'h0000;
         tgt_q        <= 1'b0;
         start_q      <= 1'b0;
         force_q      <= 1'b0;
         active_set_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         force_q <= off;
         if (off) begin
            state_q      <= S_PRI;
            tgt_q        <= 1'b0;
            active_set_q <= 1'b0;
         end else begin
            case (state_q)
               S_PRI: begin
                  if (auto_on && cond_a) begin
                     state_q <= S_WA;
                     cnt_q   <= 16'h0000;
                  end
               end
               S_WA: begin
                  if (!auto_on) begin
                     state_q <= S_PRI;
                  end else if (cnt_q >= hold_one) begin
                     state_q <= S_RA;
                     tgt_q   <= 1'b1;
                     dur_q   <= trans_one;
                     start_q <= 1'b1;
                  end else if (tick) begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               S_RA: begin
                  // the ramps raise busy one cycle after the start pulse
                  if (!start_q && ramp_busy == {NCH{1'b0}}) begin
                     state_q      <= S_SEC;
                     active_set_q <= 1'b1;
                  end
               end
               S_SEC: begin
                  if (auto_on && cond_b) begin
                     state_q <= S_WB;
                     cnt_q   <= 16'h0000;
                  end
               end
               S_WB: begin
                  if (!auto_on) begin
                     state_q <= S_SEC;
                  end else if (cnt_q >= hold_two) begin
                     state_q <= S_RB;
                     tgt_q   <= 1'b0;
                     dur_q   <= trans_two;
                     start_q <= 1'b1;
                  end else if (tick) begin
                     cnt_q <= cnt_q + 16'h0001;
                  end
               end
               S_RB: begin
                  if (!start_q && ramp_busy == {NCH{1'b0}}) begin
                     state_q      <= S_PRI;
                     active_set_q <= 1'b0;
                  end
               end
               default: begin
                  state_q <= S_PRI;
               end
            endcase
         end
      end
   end

   // integral compensation follows the settled set, only in less-deviation
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         integ_comp_en_q <= 1'b0;
         switching_q     <= 1'b0;
      end else begin
         switching_q <= (state_q != S_PRI) && (state_q != S_SEC) && !off;
         case (ic_mode)
            `SGSW_IC_BOTH: integ_comp_en_q <= ld_mode;
            `SGSW_IC_PRI:  integ_comp_en_q <= ld_mode & ~active_set_q;
            `SGSW_IC_SEC:  integ_comp_en_q <= ld_mode & active_set_q;
            default:       integ_comp_en_q <= 1'b0;
         endcase
      end
   end

   // read mux; status is read-only and writes to it are dropped
   always @* begin
      rd_d  = 32'h00000000;
      hit_d = 1'b0;
      case (paddr)
         `SGSW_OFF_CTRL: begin
            rd_d  = {{(32-`SGSW_CTRL_W){1'b0}}, ctrl_q};
            hit_d = 1'b1;
         end
         `SGSW_OFF_HOLD: begin
            rd_d  = hold_q;
            hit_d = 1'b1;
         end
         `SGSW_OFF_TRANS: begin
            rd_d  = trans_q;
            hit_d = 1'b1;
         end
         `SGSW_OFF_STATUS: begin
            rd_d  = {21'h000000, force_q, switching_q, active_set_q, 2'h0, state_q};
            hit_d = 1'b1;
         end
         default: begin
            for (i = 0; i < NCH; i = i + 1) begin
               if (pair_hit[i]) begin
                  rd_d  = pair_q[i];
                  hit_d = 1'b1;
               end
            end
         end
      endcase
   end

   // answer registered in the setup cycle, so it stands in the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit_d;
         prdata  <= (setup && !pwrite) ? rd_d : 32'h00000000;
      end
   end

endmodule // sgsw_top

// ---- sgsw_loop_model.sv ----
`timescale 1ns/1ns
// far side stand-in: flags in-position after the axis settles, passes status flags on
module sgsw_loop_model #(
   parameter integer SETTLE = 3
) (
   input  logic        pclk,
   input  logic        presetn,
   input  logic        in_pos,
   input  logic [14:0] flags,
   output logic        positioning_complete_one,
   output logic [14:0] cond_in
);
   logic [7:0] cnt_q;

   // in-position rises only after settling, like a real axis
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         positioning_complete_one <= 1'b0;
         cond_in <= 15'h0000;
      end else begin
         cnt_q <= !in_pos ? 8'h00 : (cnt_q == SETTLE) ? cnt_q : cnt_q + 8'h01;
         positioning_complete_one <= in_pos && (cnt_q == SETTLE);
         cond_in <= flags;
      end
   end
endmodule // sgsw_loop_model

// ---- sgsw_top_asserts.sv ----
`timescale 1ns/1ns
`include "sgsw_defines.vh"
// port watcher; config is mirrored from committed bus writes
module sgsw_asserts #(
   parameter integer TICK_CYC = 10
) (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        servo_on,
   input logic        alarm,
   input logic [15:0] speed_gain_q,
   input logic [15:0] position_gain_q,
   input logic        integ_comp_en_q,
   input logic        active_set_q,
   input logic        switching_q
);
   logic [17:0] ctrl_q;
   logic [15:0] spd_pri_q;
   logic [15:0] pos_sec_q;
   wire         wr_c = psel && penable && pready && pwrite && !pslverr;

   // mirror; secondary is not clamped here, so keep it in range
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `SGSW_CTRL_RST;
         spd_pri_q <= 16'h0190;
         pos_sec_q <= 16'h0190;
      end else if (wr_c) begin
         if (paddr == `SGSW_OFF_CTRL) ctrl_q <= pwdata[17:0];
         if (paddr == 12'h00C) spd_pri_q <= pwdata[15:0];
         if (paddr == 12'h014) pos_sec_q <= pwdata[31:16];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence forced_s; (!servo_on || alarm)[*4]; endsequence

   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data outside access");
   switch_gated_a: assert property ($rose(switching_q) |-> ctrl_q[3:0] == 4'h1)
      else $error("switch started with wrong pattern");
   force_idle_a: assert property (forced_s |-> !switching_q && !active_set_q)
      else $error("forced state not primary");
   force_gain_a: assert property (forced_s |-> speed_gain_q == spd_pri_q)
      else $error("forced gain not primary");
   set_gain_a: assert property ($rose(active_set_q) && !ctrl_q[12] |-> position_gain_q == pos_sec_q)
      else $error("set settled before target");
   integ_std_a: assert property ((!ctrl_q[12])[*3] |-> !integ_comp_en_q)
      else $error("compensation on in standard mode");
   ld_speed_a: assert property (ctrl_q[12] && active_set_q |-> speed_gain_q == spd_pri_q)
      else $error("standard gain moved in less-deviation");
endmodule // sgsw_asserts

bind sgsw_top sgsw_asserts #(.TICK_CYC(TICK_CYC)) i_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .servo_on, .alarm, .speed_gain_q,
   .position_gain_q, .integ_comp_en_q, .active_set_q, .switching_q);

// ---- tb_servo_gain_set_switcher.sv ----
`timescale 1ns/1ns
`include "sgsw_defines.vh"
module tb_servo_gain_set_switcher;
   logic        pclk, presetn, psel, penable, pwrite, servo_on, alarm, in_pos;
   logic        pready, pslverr, pc1, integ, act, sw, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [14:0] flags, cond_in;
   logic [15:0] spd, itg, pos, tq, rig, fb;
   int          errors, compares;
   logic [2:0]  watch;

   // bits a scenario may wait on: 0 in-position, 1 active set, 2 switching
   assign watch = {sw, act, pc1};

   sgsw_top #(.TICK_CYC(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .servo_on(servo_on), .alarm(alarm),
      .positioning_complete_one(pc1), .cond_in(cond_in), .speed_gain_q(spd),
      .speed_integral_q(itg), .position_gain_q(pos), .torque_filter_q(tq), .rigidity_q(rig),
      .fb_filter_q(fb), .integ_comp_en_q(integ), .active_set_q(act), .switching_q(sw));
   sgsw_loop_model i_far (.pclk(pclk), .presetn(presetn), .in_pos(in_pos), .flags(flags),
      .positioning_complete_one(pc1), .cond_in(cond_in));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic complete_run;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // a bounded wait ran out
   task automatic hang;
      errors++;
      complete_run();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one transfer; request held until ready is sampled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdck(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask

   task automatic wait_bit(input int which, input logic v);
      int n;
      n = 0;
      while (watch[which] !== v && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) hang();
   endtask

   task automatic wait_pos(input logic [15:0] from);
      int n;
      n = 0;
      while (pos === from && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) hang();
   endtask

   // reset values, unmapped place, clamping at both ends
   task automatic t_regs;
      rdck(`SGSW_OFF_CTRL, 32'h00000000);
      rdck(`SGSW_OFF_PAIR0, `SGSW_RST_SPD);
      rdck(`SGSW_OFF_TRANS, `SGSW_TRANS_RST);
      rdck(`SGSW_OFF_STATUS, 32'h00000001);
      apb(1'b0, 12'h028, 32'h00000000);
      chk({31'h0, err}, 32'h00000001);
      chk(rd, 32'h00000000);
      wr(`SGSW_OFF_PAIR0, 32'h00050064);
      rdck(`SGSW_OFF_PAIR0, 32'h000A0064);
      wr(`SGSW_OFF_PAIR0, 32'h4E210064);
      rdck(`SGSW_OFF_PAIR0, 32'h4E200064);
      wr(12'h010, 32'hFFFF07D0);
      rdck(12'h010, 32'hC80007D0);
      wr(12'h014, 32'h00010064);
      rdck(12'h014, 32'h000A0064);
   endtask

   // in-position starts the switch, flag 1 brings it back
   task automatic t_switch;
      wr(12'h00C, 32'h01900064);
      wr(12'h010, 32'h0FA007D0);
      wr(12'h014, 32'h01900064);
      wr(12'h018, 32'h00320064);
      wr(`SGSW_OFF_HOLD, 32'h00020002);
      wr(`SGSW_OFF_TRANS, 32'h00000003);
      wr(`SGSW_OFF_CTRL, 32'h00000101);
      in_pos <= 1'b1;
      wait_bit(0, 1'b1);
      repeat (18) @(posedge pclk);
      chk(pos, 16'h0064);
      chk(act, 1'b0);
      wait_pos(16'h0064);
      chk(pos, 16'h00C8);
      wait_bit(1, 1'b1);
      chk({spd, itg}, 32'h01900FA0);
      chk({pos, tq}, 32'h01900032);
      in_pos <= 1'b0;
      flags <= 15'h0001;
      repeat (9) @(posedge pclk);
      chk(pos, 16'h0190);
      wait_pos(16'h0190);
      chk(pos, 16'h0064);
      wait_bit(1, 1'b0);
      chk({spd, tq}, 32'h00640064);
      flags <= 15'h0000;
   endtask

   // pattern other than one must never switch
   task automatic t_pattern;
      wr(`SGSW_OFF_CTRL, 32'h00000102);
      in_pos <= 1'b1;
      repeat (60) @(posedge pclk);
      chk({act, sw}, 2'b00);
      in_pos <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask

   // servo off, then alarm, in mid hold-off
   task automatic t_force;
      int i;
      wr(`SGSW_OFF_HOLD, 32'h00010005);
      wr(`SGSW_OFF_CTRL, 32'h00000101);
      for (i = 0; i < 2; i++) begin
         in_pos <= 1'b1;
         wait_bit(2, 1'b1);
         servo_on <= (i == 1);
         alarm <= (i == 1);
         in_pos <= 1'b0;
         repeat (4) @(posedge pclk);
         chk({act, sw, pos}, {2'b00, 16'h0064});
         servo_on <= 1'b1;
         alarm <= 1'b0;
         repeat (80) @(posedge pclk);
         chk({act, sw}, 2'b00);
      end
   endtask

   // less-deviation: compensation decode, rigidity and filter switch
   task automatic t_lessdev;
      logic [3:0] pri_en;
      int         m;
      pri_en = 4'b0110;
      wr(12'h01C, 32'h0050003C);
      wr(12'h020, 32'h00200000);
      wr(`SGSW_OFF_HOLD, 32'h00000000);
      for (m = 0; m < 4; m++) begin
         wr(`SGSW_OFF_CTRL, 32'h00001101 | (m << 16));
         repeat (3) @(posedge pclk);
         chk(integ, pri_en[m]);
      end
      in_pos <= 1'b1;
      wait_bit(1, 1'b1);
      chk({rig, fb}, 32'h00500020);
      chk({spd, pos}, 32'h00640064);
      repeat (3) @(posedge pclk);
      chk(integ, 1'b1);
      in_pos <= 1'b0;
      flags <= 15'h0001;
      wait_bit(1, 1'b0);
      chk({rig, fb}, 32'h003C0000);
      flags <= 15'h0000;
   endtask

   // reset held two cycles, then the scenarios in turn
   initial begin
      errors = 0;
      compares = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      servo_on = 1'b1;
      alarm = 1'b0;
      in_pos = 1'b0;
      flags = 15'h0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_switch();
      t_pattern();
      t_force();
      t_lessdev();
      complete_run();
   end
endmodule // tb_servo_gain_set_switcher
